/* verilog/iop_pkg.sv */
// package: register map, reset values, widths and pin carriers of the i/o port block
package iop_pkg;
    // port widths
    localparam int P0_W = 4;
    localparam int P1_W = 8;
    localparam int P2_W = 3;
    // apb byte offsets
    localparam logic [7:0] OFF_P0_DIR = 8'h00;
    localparam logic [7:0] OFF_P0_LAT = 8'h04;
    localparam logic [7:0] OFF_P0_ODS = 8'h08;
    localparam logic [7:0] OFF_P0_PIN = 8'h0c;
    localparam logic [7:0] OFF_P1_DIR = 8'h10;
    localparam logic [7:0] OFF_P1_LAT = 8'h14;
    localparam logic [7:0] OFF_P1_PIN = 8'h18;
    localparam logic [7:0] OFF_P2_LAT = 8'h1c;
    localparam logic [7:0] OFF_P2_PIN = 8'h20;
    localparam logic [7:0] OFF_SYSCTL = 8'h24;
    localparam logic [7:0] OFF_P2_EDGE = 8'h28;
    // field positions
    localparam int SYSCTL_STOP_OE_BIT = 0;
    // reset values
    localparam logic [P0_W-1:0] P0_DIR_RST = 4'h0;
    localparam logic [P0_W-1:0] P0_LAT_RST = 4'h0;
    localparam logic [P0_W-1:0] P0_ODS_RST = 4'h0;
    localparam logic [P1_W-1:0] P1_DIR_RST = 8'h00;
    localparam logic [P1_W-1:0] P1_LAT_RST = 8'h00;
    localparam logic [P2_W-1:0] P2_LAT_RST = 3'h7;
    localparam logic SYSCTL_STOP_OE_RST = 1'b0;
    localparam logic [P2_W-1:0] P2_EDGE_RST = 3'h0;

    // levels seen on the pins
    typedef struct packed {
        logic [P0_W-1:0] p0;
        logic [P1_W-1:0] p1;
        logic [P2_W-1:0] p2;
    } iop_pin_in_s;

    // drive value and output enable of every pin
    typedef struct packed {
        logic [P0_W-1:0] p0_out;
        logic [P0_W-1:0] p0_oe;
        logic [P1_W-1:0] p1_out;
        logic [P1_W-1:0] p1_oe;
        logic [P2_W-1:0] p2_out;
        logic [P2_W-1:0] p2_oe;
    } iop_pin_out_s;
endpackage

/* verilog/iop_ports.sv */
// i/o ports 0, 1 and 2 with apb register access
//
// Function
// - output latch holds value until rewritten
// - pins sampled in sample state
// - latch written in write state
// - oscillator failure reset floats every pin
// - rmw reads latch, others read pins; here the pin view of a tri-state output pin reads its latch
// - port0 four pins, direction resets input
// - port0 latch resets to zero
// - port0 open-drain select, resets tri-state
// - tri-state: input floats, output drives latch
// - open-drain: latch low drives, high floats
// - open-drain rmw reads latch, others pins
// - port1 eight pins, direction resets input
// - port1 latch resets to zero
// - port2 three pins, latch resets one
// - port2 bits seven to three undefined
// - port2 rmw reads latch, others pins
// - port2 floats in stop mode always
// - port2 falling edge sets interrupt latch
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
module iop_ports
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system state, asynchronous to pclk
    input wire logic osc_failure_reset,
    input wire logic stop_mode,
    // pins
    input wire iop_pkg::iop_pin_in_s pin_in,
    output iop_pkg::iop_pin_out_s pin_out,
    // port 2 interrupt latches
    output logic [iop_pkg::P2_W-1:0] port2_edge_flag
);
    // whole state of the block
    typedef struct packed {
        iop_pkg::iop_pin_in_s pin_s1;              // first synchroniser stage
        iop_pkg::iop_pin_in_s pin_s2;              // second stage, safe to read
        logic [iop_pkg::P2_W-1:0] p2_prev;         // port 2 level one cycle ago
        logic ofr_s1;                              // oscillator failure, stage 1
        logic ofr_s2;                              // oscillator failure, stage 2
        logic stop_s1;                             // stop mode, stage 1
        logic stop_s2;                             // stop mode, stage 2
        logic [iop_pkg::P0_W-1:0] port0_direction;
        logic [iop_pkg::P0_W-1:0] port0_output_latch;
        logic [iop_pkg::P0_W-1:0] port0_opendrain_select;
        logic [iop_pkg::P1_W-1:0] port1_direction;
        logic [iop_pkg::P1_W-1:0] port1_output_latch;
        logic [iop_pkg::P2_W-1:0] port2_output_latch;
        logic stop_output_enable;                  // system_control_one bit
        logic [iop_pkg::P2_W-1:0] edge_flag;       // sticky falling-edge latches
        logic [31:0] rdata;                        // read data, captured at setup
        logic rerr;                                // setup address was unmapped
        iop_pkg::iop_pin_out_s pout;               // registered pin drive
    } iop_state_s;

    iop_state_s state_reg;
    iop_state_s state_next;

    // the helpers work on 8-bit words so every port shares them;
    // narrower ports pad with zero and drop the upper result bits
    // software view of a pin: driven tri-state output reads its latch, else the pin
    function automatic logic [7:0] iop_pin_view(input logic [7:0] ods, input logic [7:0] dir,
                                                input logic [7:0] lat, input logic [7:0] pin);
        iop_pin_view = (~ods & dir & lat) | ((ods | ~dir) & pin);
    endfunction

    // output enable of a pin: open-drain drives only a low latch
    function automatic logic [7:0] iop_oe(input logic [7:0] ods, input logic [7:0] dir,
                                          input logic [7:0] lat);
        iop_oe = (~ods & dir) | (ods & ~lat);
    endfunction

    // drive value: latch in tri-state, always low in open-drain
    function automatic logic [7:0] iop_drv(input logic [7:0] ods, input logic [7:0] lat);
        iop_drv = ~ods & lat;
    endfunction

    logic setup_ph;       // apb setup cycle, doubles as the sample state
    logic access_ph;      // apb access cycle, doubles as the write state
    logic wr_en;          // a write commits this edge
    logic [iop_pkg::P2_W-1:0] p2_fall;
    logic port01_off;     // ports 0 and 1 forced to float
    logic port2_off;      // port 2 forced to float
    logic [7:0] p0_oe8;
    logic [7:0] p0_drv8;
    logic [7:0] p1_oe8;
    logic [7:0] p1_drv8;
    logic [7:0] p2_oe8;
    logic [7:0] p0_view8;
    logic [7:0] p1_view8;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en = access_ph & pwrite;
    // the edge is seen on the pin, so the device's own output pulse counts too
    assign p2_fall = state_reg.p2_prev & ~state_reg.pin_s2.p2;
    // stop mode floats ports 0 and 1 unless software keeps outputs on
    assign port01_off = state_reg.ofr_s2 | (state_reg.stop_s2 & ~state_reg.stop_output_enable);
    // port 2 pin 0 is the stop release input, so stop always floats port 2
    assign port2_off = state_reg.ofr_s2 | state_reg.stop_s2;

    // per-bit drive terms, each pin from its own bit only
    assign p0_oe8 = iop_oe({4'h0, state_reg.port0_opendrain_select},
                           {4'h0, state_reg.port0_direction},
                           {4'h0, state_reg.port0_output_latch});
    assign p0_drv8 = iop_drv({4'h0, state_reg.port0_opendrain_select},
                             {4'h0, state_reg.port0_output_latch});
    assign p1_oe8 = iop_oe(8'h00, state_reg.port1_direction,
                           state_reg.port1_output_latch);
    assign p1_drv8 = iop_drv(8'h00, state_reg.port1_output_latch);
    // port 2 behaves as open-drain: latch 1 leaves the pin free for input
    assign p2_oe8 = iop_oe(8'hff, 8'h00, {5'h00, state_reg.port2_output_latch});
    // normal reads: pin level except where a tri-state output reads its latch
    assign p0_view8 = iop_pin_view({4'h0, state_reg.port0_opendrain_select},
                                   {4'h0, state_reg.port0_direction},
                                   {4'h0, state_reg.port0_output_latch},
                                   {4'h0, state_reg.pin_s2.p0});
    assign p1_view8 = iop_pin_view(8'h00, state_reg.port1_direction,
                                   state_reg.port1_output_latch,
                                   state_reg.pin_s2.p1);

    // next state
    always_comb
    begin
        state_next = state_reg;
        // two-stage synchronisers for every asynchronous input
        state_next.pin_s1 = pin_in;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.ofr_s1 = osc_failure_reset;
        state_next.ofr_s2 = state_reg.ofr_s1;
        state_next.stop_s1 = stop_mode;
        state_next.stop_s2 = state_reg.stop_s1;
        state_next.p2_prev = state_reg.pin_s2.p2;
        // reads therefore see pin levels from two edges before the setup edge
        // setup cycle samples pins into read data; access cycle presents it
        if (setup_ph)
        begin
            state_next.rerr = 1'b0;
            case (paddr)
                iop_pkg::OFF_P0_DIR: state_next.rdata = {28'h0, state_reg.port0_direction};
                // latch offsets are the read-modify-write view
                iop_pkg::OFF_P0_LAT:
                    state_next.rdata = {28'h0, state_reg.port0_output_latch};
                iop_pkg::OFF_P0_ODS: state_next.rdata = {28'h0, state_reg.port0_opendrain_select};
                iop_pkg::OFF_P0_PIN: state_next.rdata = {24'h0, p0_view8};
                iop_pkg::OFF_P1_DIR: state_next.rdata = {24'h0, state_reg.port1_direction};
                iop_pkg::OFF_P1_LAT:
                    state_next.rdata = {24'h0, state_reg.port1_output_latch};
                iop_pkg::OFF_P1_PIN: state_next.rdata = {24'h0, p1_view8};
                // upper bits of port 2 carry nothing; they read as zero
                iop_pkg::OFF_P2_LAT:
                    state_next.rdata = {29'h0, state_reg.port2_output_latch};
                iop_pkg::OFF_P2_PIN:
                    state_next.rdata = {29'h0, state_reg.pin_s2.p2};
                iop_pkg::OFF_SYSCTL: state_next.rdata = {31'h0, state_reg.stop_output_enable};
                iop_pkg::OFF_P2_EDGE: state_next.rdata = {29'h0, state_reg.edge_flag};
                default:
                begin
                    // unmapped: zero data and an error in the access cycle
                    state_next.rdata = 32'h0;
                    state_next.rerr = 1'b1;
                end
            endcase
        end
        // writes take effect only at the access edge, otherwise latches hold
        // a write that meets a failure reset is lost, which is intended
        if (wr_en)
        begin
            case (paddr)
                iop_pkg::OFF_P0_DIR: state_next.port0_direction = pwdata[iop_pkg::P0_W-1:0];
                iop_pkg::OFF_P0_LAT:
                    state_next.port0_output_latch = pwdata[iop_pkg::P0_W-1:0];
                iop_pkg::OFF_P0_ODS: state_next.port0_opendrain_select = pwdata[iop_pkg::P0_W-1:0];
                iop_pkg::OFF_P1_DIR: state_next.port1_direction = pwdata[iop_pkg::P1_W-1:0];
                iop_pkg::OFF_P1_LAT:
                    state_next.port1_output_latch = pwdata[iop_pkg::P1_W-1:0];
                iop_pkg::OFF_P2_LAT:
                    state_next.port2_output_latch = pwdata[iop_pkg::P2_W-1:0];
                iop_pkg::OFF_SYSCTL:
                    state_next.stop_output_enable = pwdata[iop_pkg::SYSCTL_STOP_OE_BIT];
                default:
                begin
                    // pin views and unmapped offsets ignore writes
                end
            endcase
        end
        // interrupt latches: write one clears, a new edge in the same cycle wins
        // flags use the synchronised level, so pulses under one cycle may be missed
        if (wr_en && paddr == iop_pkg::OFF_P2_EDGE)
        begin
            state_next.edge_flag = (state_reg.edge_flag & ~pwdata[iop_pkg::P2_W-1:0])
                | p2_fall;
        end
        else
        begin
            state_next.edge_flag = state_reg.edge_flag | p2_fall;
        end
        // the failure flag is synchronised, so a glitch under one cycle is lost
        // oscillator failure holds the configuration at its reset values
        if (state_reg.ofr_s2)
        begin
            state_next.port0_direction = iop_pkg::P0_DIR_RST;
            state_next.port0_output_latch = iop_pkg::P0_LAT_RST;
            state_next.port0_opendrain_select = iop_pkg::P0_ODS_RST;
            state_next.port1_direction = iop_pkg::P1_DIR_RST;
            state_next.port1_output_latch = iop_pkg::P1_LAT_RST;
            state_next.port2_output_latch = iop_pkg::P2_LAT_RST;
            state_next.stop_output_enable = iop_pkg::SYSCTL_STOP_OE_RST;
        end
        // registering the drive costs a cycle but keeps decode glitches off the pins
        // registered pin drive; forcing terms override the mode logic
        state_next.pout.p0_out = p0_drv8[iop_pkg::P0_W-1:0];
        state_next.pout.p0_oe = port01_off ? 4'h0 : p0_oe8[iop_pkg::P0_W-1:0];
        state_next.pout.p1_out = p1_drv8;
        state_next.pout.p1_oe = port01_off ? 8'h00 : p1_oe8;
        state_next.pout.p2_out = 3'h0;
        state_next.pout.p2_oe = port2_off ? 3'h0 : p2_oe8[iop_pkg::P2_W-1:0];
    end

    // state register; reset loads constants only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
            state_reg.port0_direction <= iop_pkg::P0_DIR_RST;
            state_reg.port0_output_latch <= iop_pkg::P0_LAT_RST;
            state_reg.port0_opendrain_select <= iop_pkg::P0_ODS_RST;
            state_reg.port1_direction <= iop_pkg::P1_DIR_RST;
            state_reg.port1_output_latch <= iop_pkg::P1_LAT_RST;
            state_reg.port2_output_latch <= iop_pkg::P2_LAT_RST;
            state_reg.stop_output_enable <= iop_pkg::SYSCTL_STOP_OE_RST;
            state_reg.edge_flag <= iop_pkg::P2_EDGE_RST;
            // port 2 idles high so no false edge is seen after reset
            state_reg.pin_s1.p2 <= 3'h7;
            state_reg.pin_s2.p2 <= 3'h7;
            state_reg.p2_prev <= 3'h7;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign prdata = state_reg.rdata;
    // every transfer is exactly one setup and one access cycle
    assign pready = 1'b1;                           // zero wait states
    assign pslverr = access_ph & state_reg.rerr;
    assign pin_out = state_reg.pout;
    assign port2_edge_flag = state_reg.edge_flag;

    // checks
    // all checks run on pclk and sleep while reset is low
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // failure reset must float every pin, whatever the configuration was
    a_osc_fail_float: assert property (state_reg.ofr_s2 |=>
        (state_reg.pout.p0_oe == 4'h0 && state_reg.pout.p1_oe == 8'h00
        && state_reg.pout.p2_oe == 3'h0))
        else $error("pins driven during oscillator failure reset");

    // a write to the port 1 latch lands at the access edge
    a_latch_write: assert property ((wr_en && paddr == iop_pkg::OFF_P1_LAT
        && !state_reg.ofr_s2) |=> state_reg.port1_output_latch == $past(pwdata[7:0]))
        else $error("port1 latch not written at access edge");

    // without a write the latch keeps its value
    a_latch_holds: assert property ((!wr_en && !state_reg.ofr_s2)
        |=> $stable(state_reg.port0_output_latch))
        else $error("port0 latch changed without a write");

    // an input read shows the synchronised pin level seen at the setup edge
    a_pin_sample: assert property ((setup_ph && paddr == iop_pkg::OFF_P1_PIN
        && state_reg.port1_direction == 8'h00)
        |=> prdata[7:0] == $past(state_reg.pin_s2.p1))
        else $error("port1 input read not taken from pins at setup");

    // the latch offset is the read-modify-write view
    a_rmw_latch: assert property ((setup_ph && paddr == iop_pkg::OFF_P2_LAT)
        |=> prdata == {29'h0, $past(state_reg.port2_output_latch)})
        else $error("port2 latch view wrong");

    // open-drain with a low latch pulls the pin down
    a_od_low_drive: assert property ((state_reg.port0_opendrain_select[0]
        && !state_reg.port0_output_latch[0] && !port01_off)
        |=> (state_reg.pout.p0_oe[0] && !state_reg.pout.p0_out[0]))
        else $error("open-drain pin with low latch not driven low");

    // open-drain with a high latch leaves the pin to its pull-up
    a_od_high_float: assert property ((state_reg.port0_opendrain_select[1]
        && state_reg.port0_output_latch[1]) |=> !state_reg.pout.p0_oe[1])
        else $error("open-drain pin with high latch driven");

    // the stop release input must stay free even with outputs kept on
    a_stop_p2_float: assert property (state_reg.stop_s2
        && state_reg.stop_output_enable |=> state_reg.pout.p2_oe == 3'h0)
        else $error("port2 driven in stop mode");

    // a falling edge is latched and stays until cleared
    a_edge_sets_flag: assert property (p2_fall[0] |=> state_reg.edge_flag[0] ##1
        (state_reg.edge_flag[0] || $past(wr_en)))
        else $error("port2 falling edge lost");

    // a tri-state output drives its latch value
    a_tri_drive: assert property ((!state_reg.port0_opendrain_select[2]
        && state_reg.port0_direction[2] && !port01_off)
        |=> state_reg.pout.p0_oe[2]
        && state_reg.pout.p0_out[2] == $past(state_reg.port0_output_latch[2]))
        else $error("tri-state output does not drive its latch");

    // a tri-state input leaves the pin floating
    a_tri_in_float: assert property ((!state_reg.port0_opendrain_select[3]
        && !state_reg.port0_direction[3]) |=> !state_reg.pout.p0_oe[3])
        else $error("tri-state input pin driven");

    // port 1 drive follows its direction and latch bit for bit
    a_p1_drive: assert property (!port01_off |=>
        state_reg.pout.p1_oe == $past(state_reg.port1_direction)
        && state_reg.pout.p1_out == $past(state_reg.port1_output_latch))
        else $error("port1 drive does not follow direction and latch");

    // port 2 pulls low only where its latch is 0, and never drives high
    a_p2_drive: assert property (!port2_off |=>
        state_reg.pout.p2_oe == ~$past(state_reg.port2_output_latch)
        && state_reg.pout.p2_out == 3'h0)
        else $error("port2 drive does not follow its latch");

    // failure reset puts the configuration back to its reset values
    a_ofr_config: assert property (state_reg.ofr_s2 |=>
        state_reg.port1_direction == iop_pkg::P1_DIR_RST
        && state_reg.port0_opendrain_select == iop_pkg::P0_ODS_RST
        && state_reg.port2_output_latch == iop_pkg::P2_LAT_RST)
        else $error("configuration kept through oscillator failure reset");

    // a write of one clears a flag unless a new edge arrives with it
    a_edge_clear: assert property ((wr_en && paddr == iop_pkg::OFF_P2_EDGE
        && pwdata[0] && !p2_fall[0]) |=> !state_reg.edge_flag[0])
        else $error("port2 edge flag not cleared");

    // port 2 reads carry nothing above bit 2
    a_p2_upper_zero: assert property ((setup_ph && paddr == iop_pkg::OFF_P2_PIN)
        |=> prdata[31:3] == 29'h0)
        else $error("port2 read has upper bits set");

    // open-drain reads return the pin level, not the latch
    a_od_pin_read: assert property ((setup_ph && paddr == iop_pkg::OFF_P0_PIN
        && state_reg.port0_opendrain_select == 4'hf)
        |=> prdata[3:0] == $past(state_reg.pin_s2.p0))
        else $error("open-drain read not taken from pins");

    // stop mode floats port 1 unless outputs are kept on
    a_stop_p1_float: assert property (state_reg.stop_s2
        && !state_reg.stop_output_enable |=> state_reg.pout.p1_oe == 8'h00)
        else $error("port1 driven in stop mode");
endmodule

/* verif/iop_pin_model.sv */
// board model of the port pins: pull-ups plus an external driver per pin
`timescale 1ns/1ps
module iop_pin_model
(
    // drive and enables coming from the port block
    input wire iop_pkg::iop_pin_out_s pin_out,
    // external driver, held stable by the bench until it has been read
    input wire iop_pkg::iop_pin_in_s ext_val,
    input wire iop_pkg::iop_pin_in_s ext_en,
    // resolved pin levels
    output iop_pkg::iop_pin_in_s pin_in
);
    // a released, undriven pin goes to its pull-up level, never its last value
    // an enabled block driver wins over the board driver
    always_comb
    begin
        pin_in.p0 = (pin_out.p0_oe & pin_out.p0_out)
            | ~(pin_out.p0_oe | (ext_en.p0 & ~ext_val.p0));
        pin_in.p1 = (pin_out.p1_oe & pin_out.p1_out)
            | ~(pin_out.p1_oe | (ext_en.p1 & ~ext_val.p1));
        pin_in.p2 = (pin_out.p2_oe & pin_out.p2_out)
            | ~(pin_out.p2_oe | (ext_en.p2 & ~ext_val.p2));
    end
endmodule

/* verif/io_ports_p0_p2_bench.sv */
// self-checking bench of the i/o port block, apb master and pin partner
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected %s expected %h seen %h", what, exp, got); \
        end \
    end
module io_ports_p0_p2_bench;
    // clock, reset, apb and system inputs, all defined from time zero
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, osc_failure_reset = 1'b0, stop_mode = 1'b0;
    // pin side: block drive, board driver and resolved levels
    iop_pkg::iop_pin_out_s pin_out;
    iop_pkg::iop_pin_in_s pin_in, ext_val = '0, ext_en = '0;
    logic [2:0] port2_edge_flag;
    int num_errors = 0, n_compared = 0, cycles = 0;

    iop_ports iop_ports_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_failure_reset(osc_failure_reset), .stop_mode(stop_mode),
        .pin_in(pin_in), .pin_out(pin_out), .port2_edge_flag(port2_edge_flag));
    iop_pin_model iop_pin_model_i (.pin_out(pin_out), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(pin_in));

    // 125 mhz clock
    always #4 pclk = ~pclk;

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next request never lands in the same time step
        @(posedge pclk);
    endtask

    // register write, no error expected on mapped offsets
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        `CHK("write error", 1'b0, err)
    endtask

    // register read compared with a value worked out here
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        `CHK("read data", exp, rd)
        `CHK("read error", 1'b0, err)
    endtask

    // pins pass a two-flop synchroniser and a register before they show
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    // reset values of every register except the port 2 edge flags, and of the pin drivers
    task automatic t_reset();
        rchk(iop_pkg::OFF_P0_DIR, 32'h0);
        rchk(iop_pkg::OFF_P0_LAT, 32'h0);
        rchk(iop_pkg::OFF_P0_ODS, 32'h0);
        rchk(iop_pkg::OFF_P1_DIR, 32'h0);
        rchk(iop_pkg::OFF_P1_LAT, 32'h0);
        rchk(iop_pkg::OFF_P2_LAT, 32'h7);
        rchk(iop_pkg::OFF_SYSCTL, 32'h0);
        `CHK("reset oe", 15'h0, {pin_out.p0_oe, pin_out.p1_oe, pin_out.p2_oe})
        `CHK("pready", 1'b1, pready)
    endtask

    // port 0 tri-state: mixed directions against an external driver
    task automatic t_tristate();
        wr(iop_pkg::OFF_P0_DIR, 32'h5);
        wr(iop_pkg::OFF_P0_LAT, 32'h3);
        ext_en.p0 <= 4'hf;
        ext_val.p0 <= 4'ha;
        settle();
        `CHK("p0 oe", 4'h5, pin_out.p0_oe)
        `CHK("p0 out", 4'h1, pin_out.p0_out & 4'h5)
        rchk(iop_pkg::OFF_P0_PIN, 32'hb);
        rchk(iop_pkg::OFF_P0_LAT, 32'h3);
        repeat (20) @(posedge pclk);
        `CHK("p0 held", 4'h1, pin_out.p0_out & pin_out.p0_oe)
    endtask

    // port 0 open-drain: latch low pulls down, latch high floats, direction ignored
    task automatic t_opendrain();
        wr(iop_pkg::OFF_P0_ODS, 32'hf);
        wr(iop_pkg::OFF_P0_LAT, 32'h6);
        ext_val.p0 <= 4'h2;
        settle();
        `CHK("p0 od oe", 4'h9, pin_out.p0_oe)
        `CHK("p0 od out", 4'h0, pin_out.p0_out & 4'h9)
        rchk(iop_pkg::OFF_P0_PIN, 32'h2);
        rchk(iop_pkg::OFF_P0_LAT, 32'h6);
    endtask

    // port 1: upper nibble out, lower nibble in
    task automatic t_port1();
        wr(iop_pkg::OFF_P1_DIR, 32'hf0);
        wr(iop_pkg::OFF_P1_LAT, 32'ha5);
        ext_en.p1 <= 8'hff;
        ext_val.p1 <= 8'h3c;
        settle();
        `CHK("p1 oe", 8'hf0, pin_out.p1_oe)
        `CHK("p1 out", 8'ha0, pin_out.p1_out & 8'hf0)
        rchk(iop_pkg::OFF_P1_PIN, 32'hac);
        rchk(iop_pkg::OFF_P1_LAT, 32'ha5);
    endtask

    // port 2: own drive and an outside low both set edge flags
    task automatic t_port2();
        ext_en.p2 <= 3'h1;
        ext_val.p2 <= 3'h0;
        wr(iop_pkg::OFF_P2_LAT, 32'h5);
        settle();
        `CHK("p2 oe", 3'h2, pin_out.p2_oe)
        `CHK("p2 out", 3'h0, pin_out.p2_out)
        rchk(iop_pkg::OFF_P2_PIN, 32'h4);
        rchk(iop_pkg::OFF_P2_LAT, 32'h5);
        `CHK("p2 flags", 3'h3, port2_edge_flag)
        ext_en.p2 <= 3'h0;
        wr(iop_pkg::OFF_P2_LAT, 32'h7);
        settle();
        wr(iop_pkg::OFF_P2_EDGE, 32'h7);
        rchk(iop_pkg::OFF_P2_EDGE, 32'h0);
    endtask

    // stop mode: port 2 always floats, port 1 follows the stop output enable
    task automatic t_stop();
        wr(iop_pkg::OFF_P2_LAT, 32'h6);
        wr(iop_pkg::OFF_SYSCTL, 32'h1);
        stop_mode <= 1'b1;
        settle();
        `CHK("stop p2 oe", 3'h0, pin_out.p2_oe)
        `CHK("stop p1 oe", 8'hf0, pin_out.p1_oe)
        stop_mode <= 1'b0;
        wr(iop_pkg::OFF_SYSCTL, 32'h0);
        stop_mode <= 1'b1;
        settle();
        `CHK("stop p1 off", 8'h00, pin_out.p1_oe)
        stop_mode <= 1'b0;
        settle();
        `CHK("run p2 oe", 3'h1, pin_out.p2_oe)
    endtask

    // oscillator failure: every pin floats, writes ignored, config back to reset
    task automatic t_ofr();
        osc_failure_reset <= 1'b1;
        settle();
        `CHK("ofr oe", 15'h0, {pin_out.p0_oe, pin_out.p1_oe, pin_out.p2_oe})
        wr(iop_pkg::OFF_P1_DIR, 32'hff);
        osc_failure_reset <= 1'b0;
        settle();
        rchk(iop_pkg::OFF_P1_DIR, 32'h0);
        rchk(iop_pkg::OFF_P1_PIN, 32'h3c);
        rchk(iop_pkg::OFF_P2_LAT, 32'h7);
    endtask

    // unmapped offset answers with an error and zero data
    task automatic t_unmapped();
        logic [31:0] rd;
        logic err;
        apb(1'b0, 8'h2c, 32'h0, rd, err);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
    endtask

    // verdict and end of run
    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reset for 20 cycles, then the scenarios in turn
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tristate();
        t_opendrain();
        t_port1();
        t_port2();
        t_stop();
        t_ofr();
        t_unmapped();
        print_verdict();
    end
endmodule
